// ### core/ast_consts.svh
/*
 Constants for the sample-timing and repeat block: register offsets,
 field positions, reset values and stage limits.
 Assumes inclusion by the core module only.
*/
// Summary of operation
// - Charge period is 13 bits, two bytes
// - Nonzero charge N lasts exactly N clocks
// - Zero charge setting skips the charge stage
// - Sampling window is 13 bits, N clocks
// - Zero window skipped only if charge zero
// - Five-bit load select adds N picofarads
// - Repeat threshold sets triggers before test
// - Trigger tally counts converter triggers
// - Averaging modes output shifted running sum
// - Lowpass mode outputs filter result
// - Output high byte read-only, signed
// - Settings reset zero, tally keeps value
// - Upper three bits unimplemented, read zero
// - Clock choice clear selects system clock
// - Output low byte read-only, same computation
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
`define AST_OFF_CHARGE_LO 12'h000
`define AST_OFF_CHARGE_HI 12'h004
`define AST_OFF_WINDOW_LO 12'h008
`define AST_OFF_WINDOW_HI 12'h00C
`define AST_OFF_LOAD 12'h010
`define AST_OFF_GOAL 12'h014
`define AST_OFF_TALLY 12'h018
`define AST_OFF_OUT_HI 12'h01C
`define AST_OFF_OUT_LO 12'h020
`define AST_OFF_CTRL 12'h024
`define AST_OFF_STATUS 12'h028
`define AST_HI_BITS 5
`define AST_RST_BYTE 8'h00
`define AST_RST_TIME 13'h0000
`define AST_WIN_ZERO_LEN 14'h2000
`define AST_CTRL_TRIG_BIT 0
`define AST_CTRL_RC_BIT 1
`define AST_CTRL_MODE_LSB 2
`define AST_CTRL_SHIFT_LSB 4
`endif

// ### core/ast_core.sv
/*
 Sample timing, extra load select, repeat tally and smoothed output
 registers behind an APB slave with byte registers in 32-bit words.
 Assumes the running sum and lowpass result come from the math unit,
 and the dedicated RC clock arrives as a pulse synchronous to CLK_SYS_I.
*/
// Added by the designer: the address map and the APB register port.
`include "ast_consts.svh"
`default_nettype none
module ast_core
   import ast_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic POR_I,
   // APB
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Converter side
   input wire logic RC_TICK_I,
   input wire logic [17:0] RUNNING_SUM_I,
   input wire logic [15:0] LOWPASS_I,
   input wire logic RESULT_VALID_I,
   output logic [4:0] EXTRA_LOAD_O,
   output logic CHARGE_ACTIVE_O,
   output logic WINDOW_ACTIVE_O,
   output logic SAMPLE_DONE_O,
   output logic THRESH_TEST_O
);
   logic [7:0] charge_lo_q, window_lo_q, goal_q, tally_q;
   logic [4:0] charge_hi_q, window_hi_q, load_q;
   logic rc_sel_q, trig_q, busy_q;
   logic [1:0] mode_q;
   logic [3:0] shift_q;
   logic [15:0] out_q;
   logic [13:0] cnt_q;
   ast_state_e state_q;
   logic [12:0] charge_set, window_set;
   logic setup, wr, rd, tick, err;
   logic wr_charge_lo, wr_charge_hi, wr_window_lo, wr_window_hi;
   logic wr_load, wr_goal, wr_tally, wr_ctrl;
   logic [7:0] rbyte;

   assign charge_set = {charge_hi_q, charge_lo_q};
   assign window_set = {window_hi_q, window_lo_q};
   assign setup = PSEL_I && !PENABLE_I;
   // Writes land in the access cycle, so an abandoned setup changes nothing
   assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
   assign rd = setup && !PWRITE_I;
   // RC clock counts only when selected, otherwise every system clock
   assign tick = rc_sel_q ? RC_TICK_I : 1'b1;

   // Write strobes: one per writable register (none for output or status), decoded once for all update blocks
   always_comb
   begin
      wr_charge_lo = 1'b0;
      wr_charge_hi = 1'b0;
      wr_window_lo = 1'b0;
      wr_window_hi = 1'b0;
      wr_load = 1'b0;
      wr_goal = 1'b0;
      wr_tally = 1'b0;
      wr_ctrl = 1'b0;
      if (wr)
      begin
         if (PADDR_I == `AST_OFF_CHARGE_LO)
            wr_charge_lo = 1'b1;
         else if (PADDR_I == `AST_OFF_CHARGE_HI)
            wr_charge_hi = 1'b1;
         else if (PADDR_I == `AST_OFF_WINDOW_LO)
            wr_window_lo = 1'b1;
         else if (PADDR_I == `AST_OFF_WINDOW_HI)
            wr_window_hi = 1'b1;
         else if (PADDR_I == `AST_OFF_LOAD)
            wr_load = 1'b1;
         else if (PADDR_I == `AST_OFF_GOAL)
            wr_goal = 1'b1;
         else if (PADDR_I == `AST_OFF_TALLY)
            wr_tally = 1'b1;
         else if (PADDR_I == `AST_OFF_CTRL)
            wr_ctrl = 1'b1;
      end
   end

   // Charge period: cleared by SRST_I only, not by POR_I, bytes written separately
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         charge_lo_q <= `AST_RST_BYTE;
         charge_hi_q <= 5'h00;
      end
      else if (wr_charge_lo)
         charge_lo_q <= PWDATA_I[7:0];
      else if (wr_charge_hi)
         charge_hi_q <= PWDATA_I[`AST_HI_BITS-1:0];
   end

   // Sampling window: no latch between the bytes, a stage may see a mix
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         window_lo_q <= `AST_RST_BYTE;
         window_hi_q <= 5'h00;
      end
      else if (wr_window_lo)
         window_lo_q <= PWDATA_I[7:0];
      else if (wr_window_hi)
         window_hi_q <= PWDATA_I[`AST_HI_BITS-1:0];
   end

   // Extra load select: upper three write bits are simply not stored
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         load_q <= 5'h00;
      else if (wr_load)
         load_q <= PWDATA_I[`AST_HI_BITS-1:0];
   end

   // Repeat threshold
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         goal_q <= `AST_RST_BYTE;
      else if (wr_goal)
         goal_q <= PWDATA_I[7:0];
   end

   // Control: clock choice, mode and output shift
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         rc_sel_q <= 1'b0;
         mode_q <= AST_M_ACCUM;
         shift_q <= 4'h0;
      end
      else if (wr_ctrl)
      begin
         rc_sel_q <= PWDATA_I[`AST_CTRL_RC_BIT];
         mode_q <= PWDATA_I[`AST_CTRL_MODE_LSB +: 2];
         shift_q <= PWDATA_I[`AST_CTRL_SHIFT_LSB +: 4];
      end
   end

   // Registered copy so the load pins never glitch during a decode
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         EXTRA_LOAD_O <= 5'h00;
      else
         EXTRA_LOAD_O <= load_q;
   end

   // Trigger request: software write of the trigger bit, held until taken
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         trig_q <= 1'b0;
      else if (wr_ctrl && PWDATA_I[`AST_CTRL_TRIG_BIT])
         trig_q <= 1'b1;
      else if (state_q == AST_IDLE)
         trig_q <= 1'b0;
   end

   // Sample sequencer
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         state_q <= AST_IDLE;
         cnt_q <= 14'h0000;
         SAMPLE_DONE_O <= 1'b0;
      end
      else
      begin
         SAMPLE_DONE_O <= 1'b0;
         case (state_q)
            AST_IDLE:
               if (trig_q)
               begin
                  if (charge_set != `AST_RST_TIME)
                  begin
                     state_q <= AST_CHARGE;
                     cnt_q <= {1'b0, charge_set};
                  end
                  else if (window_set != `AST_RST_TIME)
                  begin
                     state_q <= AST_WINDOW;
                     cnt_q <= {1'b0, window_set};
                  end
                  else
                     SAMPLE_DONE_O <= 1'b1;
               end
            AST_CHARGE:
               if (tick)
               begin
                  if (cnt_q == 14'h0001)
                  begin
                     state_q <= AST_WINDOW;
                     // Zero window after a charge stage means full length
                     cnt_q <= (window_set == `AST_RST_TIME) ?
                              `AST_WIN_ZERO_LEN : {1'b0, window_set};
                  end
                  else
                     cnt_q <= cnt_q - 14'h0001;
               end
            AST_WINDOW:
               if (tick)
               begin
                  if (cnt_q == 14'h0001)
                  begin
                     state_q <= AST_IDLE;
                     SAMPLE_DONE_O <= 1'b1;
                  end
                  else
                     cnt_q <= cnt_q - 14'h0001;
               end
            // Unused encoding: recover to idle rather than hang
            default:
               state_q <= AST_IDLE;
         endcase
      end
   end

   // Stage flags trail the state by one cycle
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         CHARGE_ACTIVE_O <= 1'b0;
         WINDOW_ACTIVE_O <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         CHARGE_ACTIVE_O <= (state_q == AST_CHARGE);
         WINDOW_ACTIVE_O <= (state_q == AST_WINDOW);
         busy_q <= (state_q != AST_IDLE);
      end
   end

   // Tally survives ordinary resets; only power-on clears it
   always_ff @(posedge CLK_SYS_I)
   begin
      if (POR_I)
      begin
         tally_q <= `AST_RST_BYTE;
         THRESH_TEST_O <= 1'b0;
      end
      else if (SRST_I)
         THRESH_TEST_O <= 1'b0;
      else
      begin
         THRESH_TEST_O <= 1'b0;
         // A goal of 0 or 1 tests after every sample outside accumulate mode
         if (SAMPLE_DONE_O)
         begin
            if (mode_q != AST_M_ACCUM && tally_q + 8'h01 >= goal_q)
            begin
               tally_q <= 8'h00;
               THRESH_TEST_O <= 1'b1;
            end
            else
               tally_q <= tally_q + 8'h01;
         end
         else if (wr_tally)
            tally_q <= PWDATA_I[7:0];
      end
   end

   // Smoothed output: left as is by reset
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RESULT_VALID_I)
      begin
         if (mode_q == AST_M_LPF)
            out_q <= LOWPASS_I;
         else
            // Arithmetic shift keeps the sign of the running sum
            out_q <= 16'($signed(RUNNING_SUM_I) >>> shift_q);
      end
   end

   always_comb
   begin
      rbyte = 8'h00;
      err = 1'b0;
      if (PADDR_I == `AST_OFF_CHARGE_LO)
         rbyte = charge_lo_q;
      else if (PADDR_I == `AST_OFF_CHARGE_HI)
         rbyte = {3'h0, charge_hi_q};
      else if (PADDR_I == `AST_OFF_WINDOW_LO)
         rbyte = window_lo_q;
      else if (PADDR_I == `AST_OFF_WINDOW_HI)
         rbyte = {3'h0, window_hi_q};
      else if (PADDR_I == `AST_OFF_LOAD)
         rbyte = {3'h0, load_q};
      else if (PADDR_I == `AST_OFF_GOAL)
         rbyte = goal_q;
      else if (PADDR_I == `AST_OFF_TALLY)
         rbyte = tally_q;
      else if (PADDR_I == `AST_OFF_OUT_HI)
         rbyte = out_q[15:8];
      else if (PADDR_I == `AST_OFF_OUT_LO)
         rbyte = out_q[7:0];
      else if (PADDR_I == `AST_OFF_CTRL)
         rbyte = {shift_q, mode_q, rc_sel_q, 1'b0};
      else if (PADDR_I == `AST_OFF_STATUS)
         rbyte = {5'h00, busy_q, state_q};
      else
         err = 1'b1;
   end

   // No wait state: answer registered in the setup cycle
   // Read data stands from the access cycle until the next read
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O <= setup;
         PSLVERR_O <= setup && err;
         if (rd)
            PRDATA_O <= {24'h00_0000, rbyte};
      end
   end
endmodule
`default_nettype wire

// ### core/ast_pkg.sv
/*
 Types shared by the sample-timing block.
 Assumes nothing beyond the constants header.
*/
`default_nettype none
package ast_pkg;
   typedef enum logic [1:0] {
      AST_IDLE = 2'b00,
      AST_CHARGE = 2'b01,
      AST_WINDOW = 2'b11
   } ast_state_e;
   typedef enum logic [1:0] {
      AST_M_ACCUM = 2'b00,
      AST_M_AVG = 2'b01,
      AST_M_BURST = 2'b10,
      AST_M_LPF = 2'b11
   } ast_mode_e;
endpackage
`default_nettype wire

// ### tb/ast_core_properties.sv
/* Port assertions for the sample-timing block.
   Assumes it is bound to ast_core, one clock domain. */
`default_nettype none
module ast_chk (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   // Bus side
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Converter side
   input wire logic [4:0] EXTRA_LOAD_O,
   input wire logic CHARGE_ACTIVE_O,
   input wire logic WINDOW_ACTIVE_O,
   input wire logic SAMPLE_DONE_O,
   input wire logic THRESH_TEST_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   chk_reset_quiet: assert property ($fell(SRST_I) |-> !(CHARGE_ACTIVE_O ||
      WINDOW_ACTIVE_O || SAMPLE_DONE_O || THRESH_TEST_O || PREADY_O))
      else $error("outputs active after reset");
   chk_load_copy: assert property (s_setup ##0 PWRITE_I && PADDR_I == 12'h010
      |-> ##3 EXTRA_LOAD_O == $past(PWDATA_I[4:0], 3)) else $error("load pins wrong");
   chk_high_zero: assert property (s_setup ##0 !PWRITE_I &&
      PADDR_I inside {12'h004, 12'h00C, 12'h010} |=> PREADY_O && PRDATA_O[31:5] == 27'h0)
      else $error("unused bits read nonzero");
   chk_stage_excl: assert property (!(CHARGE_ACTIVE_O && WINDOW_ACTIVE_O))
      else $error("both stages active");
   chk_window_follow: assert property (!$past(SRST_I) && $fell(CHARGE_ACTIVE_O)
      |-> WINDOW_ACTIVE_O) else $error("no window after charge");
   chk_thresh_after: assert property (THRESH_TEST_O |-> $past(SAMPLE_DONE_O))
      else $error("threshold test without sample");
   chk_done_end: assert property (!$past(SRST_I) && $fell(WINDOW_ACTIVE_O)
      |-> SAMPLE_DONE_O || $past(SAMPLE_DONE_O) or ##1 SAMPLE_DONE_O)
      else $error("window end without done");
   chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
endmodule
bind ast_core ast_chk u_ast_chk (.CLK_SYS_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
   .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .EXTRA_LOAD_O,
   .CHARGE_ACTIVE_O, .WINDOW_ACTIVE_O, .SAMPLE_DONE_O, .THRESH_TEST_O);
`default_nettype wire

// ### tb/ast_core_tb.sv
/* Self-checking bench for ast_core, registers over APB.
   Assumes the checker is bound in its own file. */
`default_nettype none
module ast_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] x;} ast_row_s;
   typedef struct {logic [12:0] c; logic [12:0] w; logic [7:0] m;
      int nc; int nw; int nt;} ast_run_s;
   ast_row_s rows[6] = '{'{12'h000, 8'hFF, 8'hFF}, '{12'h004, 8'hFF, 8'h1F},
      '{12'h008, 8'hA5, 8'hA5}, '{12'h00C, 8'hE3, 8'h03}, '{12'h010, 8'hFF, 8'h1F},
      '{12'h014, 8'h03, 8'h03}};
   ast_run_s runs[5] = '{'{13'h0003, 13'h0005, 8'h09, 3, 5, 0},
      '{13'h0000, 13'h0004, 8'h05, 0, 4, 0}, '{13'h0002, 13'h0000, 8'h05, 2, 8192, 1},
      '{13'h0000, 13'h0000, 8'h01, 0, 0, 0}, '{13'h1FFF, 13'h0001, 8'h01, 8191, 1, 0}};
   logic clk, srst, por, psel, pen, pwr, rv, rdy, serr, err, chg, win, sd, thr;
   logic [1:0] div = 2'h0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, t;
   logic [4:0] load;
   logic [17:0] sum;
   logic [15:0] lp;
   int bad_count, n_compared, nc, nw, nt, nd, c0, w0, t0, d0, k;
   ast_core u_ast_core (.CLK_SYS_I(clk), .SRST_I(srst), .POR_I(por), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(serr), .RC_TICK_I(div == 2'h3),
      .RUNNING_SUM_I(sum), .LOWPASS_I(lp), .RESULT_VALID_I(rv), .EXTRA_LOAD_O(load),
      .CHARGE_ACTIVE_O(chg), .WINDOW_ACTIVE_O(win), .SAMPLE_DONE_O(sd), .THRESH_TEST_O(thr));
   // Free-running tick every fourth cycle; ignored unless the RC choice is set
   always @(posedge clk)
   begin
      div <= div + 2'h1;
      nc <= nc + (chg === 1'b1);
      nw <= nw + (win === 1'b1);
      nt <= nt + (thr === 1'b1);
      nd <= nd + (sd === 1'b1);
   end
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   // One idle cycle follows each transfer so no signal is assigned twice per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (k = 0; k < 20 && rdy !== 1'b1; k++)
         @(posedge clk);
      rd = prdata;
      err = serr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (k >= 20)
      begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic rdchk(input string n, input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0);
      chk(n, {24'h0, x}, rd);
   endtask
   task automatic run(input ast_run_s r);
      apb(1'b1, 12'h000, {24'h0, r.c[7:0]});
      apb(1'b1, 12'h004, {27'h0, r.c[12:8]});
      apb(1'b1, 12'h008, {24'h0, r.w[7:0]});
      apb(1'b1, 12'h00C, {27'h0, r.w[12:8]});
      {c0, w0, t0, d0} = {nc, nw, nt, nd};
      apb(1'b1, 12'h024, {24'h0, r.m});
      for (k = 0; k < 9000 && nd == d0; k++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      if (k >= 9000)
      begin
         chk("sample done", 1, 0);
         test_done();
      end
   endtask
   task automatic smooth(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo);
      apb(1'b1, 12'h024, {24'h0, m});
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      rdchk("out high", 12'h01C, hi);
      rdchk("out low", 12'h020, lo);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      {srst, por, psel, pen, pwr, rv, paddr, pwdata, sum, lp} = '0;
      {srst, por} = 2'b11;
      {bad_count, n_compared, nc, nw, nt, nd} = '0;
      repeat (12) @(posedge clk);
      {srst, por} <= 2'b00;
      foreach (rows[i])
      begin
         rdchk("reset value", rows[i].a, 8'h00);
         apb(1'b1, rows[i].a, {24'hFFFFFF, rows[i].d});
         rdchk("read back", rows[i].a, rows[i].x);
      end
      chk("load pins", 5'h1F, load);
      $display("registers done");
      foreach (runs[i])
      begin
         run(runs[i]);
         chk("charge cycles", runs[i].nc, nc - c0);
         chk("window cycles", runs[i].nw, nw - w0);
         chk("threshold tests", runs[i].nt, nt - t0);
         if (i == 1)
            rdchk("tally", 12'h018, 8'h02);
      end
      run('{13'h0002, 13'h0002, 8'h03, 0, 0, 0});
      chk("rc span", 1, (nc + nw - c0 - w0) inside {[12:17]});
      $display("sequencer done");
      sum <= 18'h3FFF0;
      lp <= 16'hBEEF;
      smooth(8'h40, 8'hFF, 8'hFF);
      smooth(8'h0C, 8'hBE, 8'hEF);
      apb(1'b1, 12'h01C, 32'h0);
      rdchk("out read only", 12'h01C, 8'hBE);
      apb(1'b1, 12'h030, 32'h1);
      chk("unmapped error", 1, err);
      rdchk("unmapped read", 12'h030, 8'h00);
      rdchk("ctrl read", 12'h024, 8'h0C);
      rdchk("status idle", 12'h028, 8'h00);
      apb(1'b1, 12'h018, 32'h5A);
      rdchk("tally write", 12'h018, 8'h5A);
      $display("output done");
      apb(1'b0, 12'h018, 32'h0);
      t = rd;
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      foreach (rows[i])
         rdchk("after reset", rows[i].a, 8'h00);
      rdchk("tally kept", 12'h018, t[7:0]);
      chk("load cleared", 5'h00, load);
      $display("reset done");
      test_done();
   end
endmodule
`default_nettype wire
